// >>> common/seq_pkg.sv
// Package of constants and types for the program sequencer and its return stack.
package seq_pkg;

  // Address widths and stack depth per variant (13/12/11 bits, 12/8/6 levels).
  localparam int PC_WIDTH_DEF    = 13;
  localparam int STACK_DEPTH_DEF = 12;
  localparam int LOW_BYTE_W      = 8;

  // Avalon-MM byte offsets.
  localparam logic [3:0] OFS_LOW_BYTE = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_EN = 4'h8;

  // Status register field positions.
  localparam int STATUS_CARRY_BIT = 0;
  localparam int STATUS_ZERO_BIT  = 1;

  // Reset values.
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam logic [7:0] RESET_VECTOR = 8'h00;

  // Interrupt sources in priority order, highest first.
  localparam int NUM_INT = 6;
  localparam logic [7:0] VEC_TABLE [NUM_INT] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};

  typedef enum logic [2:0] {
    OP_NEXT      = 3'h0,
    OP_SKIP      = 3'h1,
    OP_BRANCH    = 3'h2,
    OP_CALL      = 3'h3,
    OP_SUB_EXIT  = 3'h4,
    OP_INT_EXIT  = 3'h5,
    OP_LOW_LOAD  = 3'h6,
    OP_LOW_ADD   = 3'h7
  } op_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DUMMY = 2'b01
  } seq_state_type;

endpackage : seq_pkg

// >>> common/stack_if.sv
// Interface between the sequencer and its hardware return stack.
`timescale 1ns/1ps
`default_nettype none
interface stack_if #(parameter int PC_W = 13);
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_addr;
  logic            full;
  logic            overflow;

  modport seq (output push, output pop, output push_addr,
               input top_addr, input full, input overflow);
  modport stk (input push, input pop, input push_addr,
               output top_addr, output full, output overflow);
endinterface : stack_if
`default_nettype wire

// >>> rtl/return_stack.sv
// Hardware return stack holding program counter values.
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import seq_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH_DEF,
  parameter int PC_W  = PC_WIDTH_DEF
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  stack_if.stk      bus
);
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] LEVEL_FULL = LW'(DEPTH);

  logic [PC_W-1:0] entry_reg [DEPTH];
  logic [LW-1:0]   level_reg;
  logic            overflow_reg;

  wire             is_full   = (level_reg == LEVEL_FULL);
  wire             is_empty  = (level_reg == '0);
  wire [LW-1:0]    top_index = is_empty ? '0 : level_reg - LW'(1);
  // A push into a full stack overwrites the top entry: the previous top return is lost.
  wire [LW-1:0]    push_index = is_full ? top_index : level_reg;
  wire [LW-1:0]    level_next = bus.push ? (is_full ? level_reg : level_reg + LW'(1))
                              : (bus.pop && !is_empty) ? level_reg - LW'(1) : level_reg;

  assign bus.top_addr = entry_reg[top_index];
  assign bus.full     = is_full;
  assign bus.overflow = overflow_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_reg    <= '0;
      overflow_reg <= 1'b0;
    end else if (i_ce) begin
      level_reg    <= level_next;
      overflow_reg <= overflow_reg | (bus.push & is_full);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_ce && bus.push) begin
      entry_reg[push_index] <= bus.push_addr;
    end
  end

  chk_push_stores: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && bus.push |=> bus.top_addr == $past(bus.push_addr))
    else $error("pushed address not on top of stack");

  chk_level_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    level_reg <= LEVEL_FULL)
    else $error("stack level beyond depth");

endmodule : return_stack
`default_nettype wire

// >>> rtl/program_sequencer_stack.sv
// Program counter sequencing with return stack, vectors and low byte register access.
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_stack
  import seq_pkg::*;
#(
  parameter int PC_W  = PC_WIDTH_DEF,
  parameter int DEPTH = STACK_DEPTH_DEF
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  // Avalon-MM slave.
  input  wire logic [3:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Instruction decoder side.
  input  wire logic                 i_step,
  input  wire logic [2:0]           i_op,
  input  wire logic [PC_W-1:0]      i_target,
  input  wire logic [7:0]           i_operand,
  output logic                      o_hold,
  output logic                      o_dummy_cycle,
  // Interrupt sources: pending request flags kept by each source.
  input  wire logic [NUM_INT-1:0]   i_int_req,
  output logic      [NUM_INT-1:0]   o_int_ack,
  // Program memory side.
  output logic      [PC_W-1:0]      o_fetch_addr,
  output logic                      o_stack_full,
  output logic                      o_stack_overflow,
  output logic                      o_alu_carry
);

  // ---------------------------------------------------------------- state
  seq_state_type          state_reg;
  seq_state_type          state_next;
  logic [PC_W-1:0]        pc_reg;
  logic [PC_W-1:0]        pc_next;
  logic [NUM_INT-1:0]     int_en_reg;
  logic [NUM_INT-1:0]     int_ack_reg;
  logic                   carry_reg;
  logic                   zero_reg;
  logic                   ack_reg;
  logic [31:0]            readdata_reg;

  stack_if #(.PC_W(PC_W)) stk ();

  return_stack #(
    .DEPTH (DEPTH),
    .PC_W  (PC_W)
  ) u_stack (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .bus       (stk.stk)
  );

  // ---------------------------------------------------------------- decode
  op_type op;
  assign op = op_type'(i_op);

  wire in_run    = (state_reg == ST_RUN);
  wire exec      = i_ce && i_step && in_run;
  wire is_next   = exec && (op == OP_NEXT);
  wire is_skip   = exec && (op == OP_SKIP);
  wire is_branch = exec && (op == OP_BRANCH);
  wire is_call   = exec && (op == OP_CALL);
  wire is_return = exec && ((op == OP_SUB_EXIT) || (op == OP_INT_EXIT));
  wire is_low_ld = exec && (op == OP_LOW_LOAD);
  wire is_low_add = exec && (op == OP_LOW_ADD);

  // ---------------------------------------------------------------- bus
  wire bus_req     = i_avs_read || i_avs_write;
  wire sel_low     = (i_avs_address == OFS_LOW_BYTE);
  wire sel_status  = (i_avs_address == OFS_STATUS);
  wire sel_int_en  = (i_avs_address == OFS_INT_EN);
  wire bus_done    = i_ce && bus_req && ack_reg;
  wire bus_low_wr  = bus_done && i_avs_write && sel_low;
  wire bus_en_wr   = bus_done && i_avs_write && sel_int_en;

  // The decoder must not step while a low byte write is pending, so the two
  // sources of a page jump never collide in one cycle.
  assign o_hold = i_avs_write && sel_low;

  logic [31:0] read_value;
  // The low counter byte, status and interrupt enable are mapped.
  // Stack contents and pointer are not mapped.
  always_comb begin
    read_value = 32'h0000_0000;
    if (sel_low) begin
      read_value[LOW_BYTE_W-1:0] = pc_reg[LOW_BYTE_W-1:0];
    end else if (sel_status) begin
      read_value[STATUS_CARRY_BIT] = carry_reg;
      read_value[STATUS_ZERO_BIT]  = zero_reg;
    end else if (sel_int_en) begin
      read_value[NUM_INT-1:0] = int_en_reg;
    end
  end

  assign o_avs_waitrequest = bus_req && !ack_reg;
  assign o_avs_readdata    = readdata_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_reg      <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        readdata_reg <= read_value;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_en_reg <= INT_EN_RESET[NUM_INT-1:0];
    end else if (bus_en_wr) begin
      int_en_reg <= i_avs_writedata[NUM_INT-1:0];
    end
  end

  // ---------------------------------------------------------------- interrupts
  logic [NUM_INT-1:0] int_live;
  genvar g;
  generate
    for (g = 0; g < NUM_INT; g++) begin : g_int_gate
      assign int_live[g] = i_int_req[g] && int_en_reg[g];
    end
  endgenerate

  logic [NUM_INT-1:0] int_pick;
  logic [7:0]         int_vector;
  always_comb begin
    int_pick   = '0;
    int_vector = RESET_VECTOR;
    for (int i = NUM_INT - 1; i >= 0; i--) begin
      if (int_live[i]) begin
        int_pick   = '0;
        int_pick[i] = 1'b1;
        int_vector = VEC_TABLE[i];
      end
    end
  end

  // Interrupts are taken only behind a plain instruction, so a branch, skip or
  // return in flight always completes first. A return frees a level and the
  // next plain instruction lets a waiting request in.
  // Acknowledge withheld while full.
  wire int_take = is_next && (int_live != '0) && !stk.full && !bus_low_wr;

  // ---------------------------------------------------------------- ALU
  // Computed jump: the low counter byte plus an operand, carry kept.
  wire [LOW_BYTE_W:0] low_sum = {1'b0, pc_reg[LOW_BYTE_W-1:0]} + {1'b0, i_operand};

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (is_low_add) begin
      carry_reg <= low_sum[LOW_BYTE_W];
      zero_reg  <= (low_sum[LOW_BYTE_W-1:0] == 8'h00);
    end
  end

  // ---------------------------------------------------------------- counter
  wire [PC_W-1:0] pc_inc  = pc_reg + PC_W'(1);
  wire [PC_W-1:0] pc_page = {pc_reg[PC_W-1:LOW_BYTE_W], 8'h00};
  wire [PC_W-1:0] pc_vec  = PC_W'(int_vector);

  // Call and acknowledge push the return address.
  // A call is never blocked by a full stack.
  assign stk.push      = is_call || int_take;
  assign stk.pop       = is_return;
  assign stk.push_addr = pc_reg;

  always_comb begin
    pc_next    = pc_reg;
    state_next = state_reg;
    if (!i_ce) begin
      pc_next    = pc_reg;
      state_next = state_reg;
    end else if (bus_low_wr) begin
      pc_next    = pc_page | PC_W'(i_avs_writedata[LOW_BYTE_W-1:0]);
      state_next = ST_DUMMY;
    end else if (!in_run) begin
      // The dummy cycle fetches the new target; nothing executes.
      pc_next    = pc_inc;
      state_next = ST_RUN;
    end else if (int_take) begin
      pc_next    = pc_vec;
      state_next = ST_DUMMY;
    end else if (is_skip) begin
      pc_next    = pc_inc;
      state_next = ST_DUMMY;
    end else if (is_branch || is_call) begin
      pc_next    = i_target;
      state_next = ST_DUMMY;
    end else if (is_return) begin
      pc_next    = stk.top_addr;
      state_next = ST_DUMMY;
    end else if (is_low_ld) begin
      pc_next    = pc_page | PC_W'(i_operand);
      state_next = ST_DUMMY;
    end else if (is_low_add) begin
      pc_next    = pc_page | PC_W'(low_sum[LOW_BYTE_W-1:0]);
      state_next = ST_DUMMY;
    end else if (is_next) begin
      pc_next    = pc_inc;
      state_next = ST_RUN;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_reg      <= '0;
      state_reg   <= ST_RUN;
      int_ack_reg <= '0;
    end else if (i_ce) begin
      pc_reg      <= pc_next;
      state_reg   <= state_next;
      int_ack_reg <= int_take ? int_pick : '0;
    end
  end

  assign o_fetch_addr     = pc_reg;
  assign o_dummy_cycle    = (state_reg == ST_DUMMY);
  assign o_int_ack        = int_ack_reg;
  assign o_stack_full     = stk.full;
  assign o_stack_overflow = stk.overflow;
  assign o_alu_carry      = carry_reg;

  // ---------------------------------------------------------------- checks
  chk_plain_increment: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    is_next && !int_take && !bus_low_wr |=> pc_reg == $past(pc_reg) + PC_W'(1))
    else $error("plain instruction did not advance counter by one");

  chk_skip_dummy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    is_skip && !bus_low_wr |=> o_dummy_cycle && pc_reg == $past(pc_reg) + PC_W'(1))
    else $error("skip did not insert dummy cycle");

  chk_pcl_page_jump: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    bus_low_wr |=> o_dummy_cycle
      && pc_reg[PC_W-1:LOW_BYTE_W] == $past(pc_reg[PC_W-1:LOW_BYTE_W])
      && pc_reg[LOW_BYTE_W-1:0] == $past(i_avs_writedata[LOW_BYTE_W-1:0]))
    else $error("low byte write left page or skipped dummy");

  chk_branch_target: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (is_branch || is_call) && !bus_low_wr |=> pc_reg == $past(i_target))
    else $error("branch target not loaded");

  chk_vector_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    int_take |=> pc_reg == PC_W'($past(int_vector)) && o_int_ack == $past(int_pick)
      ##1 pc_reg == PC_W'($past(int_vector, 2)) + PC_W'(1))
    else $error("interrupt vector not loaded");

  chk_full_withhold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    stk.full |-> !int_take)
    else $error("interrupt acknowledged with full stack");

  chk_return_restore: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    is_return && !bus_low_wr |=> pc_reg == $past(stk.top_addr) && o_dummy_cycle)
    else $error("return did not restore counter");

  chk_call_roundtrip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    is_call && !bus_low_wr && !stk.full |=> stk.top_addr == $past(pc_reg))
    else $error("call did not push return address");

  chk_alu_status: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    is_low_add && !bus_low_wr |=> carry_reg == $past(low_sum[LOW_BYTE_W])
      && pc_reg[LOW_BYTE_W-1:0] == $past(low_sum[LOW_BYTE_W-1:0]))
    else $error("computed jump result or carry wrong");

endmodule : program_sequencer_stack
`default_nettype wire

// >>> sim/int_source_model.sv
// Behavioural model of the interrupt sources that hold pending flags until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module int_source_model
  import seq_pkg::*;
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_b,
  input  wire logic [NUM_INT-1:0] i_raise,
  input  wire logic [NUM_INT-1:0] i_ack,
  output var  logic [NUM_INT-1:0] o_req
);
  // A flag stays pending while the sequencer withholds its acknowledge.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_req <= '0;
    end else begin
      o_req <= (o_req | i_raise) & ~i_ack;
    end
  end
endmodule : int_source_model
`default_nettype wire

// >>> sim/program_sequencer_stack_tb_top.sv
// Self-checking bench for the program sequencer and its return stack.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module program_sequencer_stack_tb_top;
  import seq_pkg::*;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               ce = 1'b1;
  logic [3:0]         adr = 4'h0;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic [31:0]        wdat = 32'h0;
  wire  [31:0]        rdat;
  wire                wreq;
  logic               step = 1'b0;
  logic [2:0]         op = 3'h0;
  logic [12:0]        tgt = 13'h0;
  logic [7:0]         opd = 8'h0;
  wire                hold;
  wire                dummy;
  wire  [5:0]         req;
  wire  [5:0]         ack;
  logic [5:0]         raise = 6'h0;
  wire  [12:0]        fetch;
  wire                full;
  wire                ovf;
  wire                carry;
  int                 n_errors = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  logic [31:0]        q;
  typedef struct {logic [2:0] op; logic [12:0] tgt; logic [7:0] opd; logic [12:0] exp;
                  logic dum;} row_type;
  row_type rows [9] = '{
    '{3'h0, 13'h0, 8'h00, 13'h0001, 1'b0}, '{3'h0, 13'h0, 8'h00, 13'h0002, 1'b0},
    '{3'h2, 13'h1234, 8'h00, 13'h1234, 1'b1}, '{3'h3, 13'h0a00, 8'h00, 13'h0a00, 1'b1},
    '{3'h6, 13'h0, 8'h80, 13'h0a80, 1'b1}, '{3'h7, 13'h0, 8'h7f, 13'h0a00, 1'b1},
    '{3'h1, 13'h0, 8'h00, 13'h0a02, 1'b1}, '{3'h4, 13'h0, 8'h00, 13'h1235, 1'b1},
    '{3'h0, 13'h0, 8'h00, 13'h1237, 1'b0}};

  always #50 clk = ~clk;

  program_sequencer_stack #(.PC_W(13), .DEPTH(6)) dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_step(step), .i_op(op), .i_target(tgt),
    .i_operand(opd), .o_hold(hold), .o_dummy_cycle(dummy), .i_int_req(req),
    .o_int_ack(ack), .o_fetch_addr(fetch), .o_stack_full(full),
    .o_stack_overflow(ovf), .o_alu_carry(carry));

  int_source_model srcs (.i_clk_sys(clk), .i_rst_b(rst_b), .i_raise(raise), .i_ack(ack),
    .o_req(req));

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // A hung handshake ends the run through the same report.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // Executes one instruction and leaves the bench just after the taking edge has settled.
  task automatic run_op(input logic [2:0] o, input logic [12:0] t, input logic [7:0] d);
    @(posedge clk);
    step <= 1'b1;
    op   <= o;
    tgt  <= t;
    opd  <= d;
    @(posedge clk);
    step <= 1'b0;
    op   <= 3'h0;
    @(negedge clk);
  endtask : run_op

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK(fetch, 13'h0000)
    `CHK(full, 1'b0)
    `CHK(hold, 1'b0)
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].tgt, rows[i].opd);
      `CHK(fetch, rows[i].exp)
      `CHK(dummy, rows[i].dum)
      if (rows[i].dum) begin
        @(negedge clk);
        `CHK(fetch, rows[i].exp + 13'h1)
      end
      if (rows[i].op == 3'h7) begin
        `CHK(carry, 1'b1)
      end
    end
    bus(1'b1, OFS_LOW_BYTE, 32'h0000_005a);
    @(negedge clk);
    `CHK(fetch, 13'h125a)
    `CHK(dummy, 1'b1)
    bus(1'b0, OFS_LOW_BYTE, 32'h0);
    `CHK(q[31:8], 24'h0)
    `CHK(q[7:0], 8'h5b)
    bus(1'b0, 4'hc, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(q, 32'h3)
    bus(1'b1, OFS_INT_EN, 32'h0000_003f);
    bus(1'b0, OFS_INT_EN, 32'h0);
    `CHK(q, 32'h3f)
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      raise <= 6'(1 << k);
      @(posedge clk);
      raise <= 6'h0;
      run_op(3'h0, 13'h0, 8'h0);
      `CHK(ack, 6'(1 << k))
      `CHK(fetch, 13'(4 * (k + 1)))
      @(negedge clk);
    end
    `CHK(full, 1'b1)
    @(posedge clk);
    raise <= 6'h01;
    @(posedge clk);
    raise <= 6'h00;
    run_op(3'h0, 13'h0, 8'h0);
    `CHK(ack, 6'h00)
    `CHK(fetch, 13'h001a)
    run_op(3'h5, 13'h0, 8'h0);
    `CHK(dummy, 1'b1)
    `CHK(full, 1'b0)
    @(negedge clk);
    run_op(3'h0, 13'h0, 8'h0);
    `CHK(ack, 6'h01)
    `CHK(fetch, 13'h0004)
    @(negedge clk);
    run_op(3'h3, 13'h0300, 8'h0);
    `CHK(fetch, 13'h0300)
    @(negedge clk);
    `CHK(ovf, 1'b1)
    `CHK(full, 1'b1)
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(fetch, 13'h0000)
    `CHK(full, 1'b0)
    @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_INT_EN, 32'h0);
    `CHK(q, 32'h0)
    wrap_up();
  end
endmodule : program_sequencer_stack_tb_top
`default_nettype wire
